//--- popjd_decoder.sv
// Purpose: decode and execute of port output, serial swap and page jumps
// Assumes: rom_data holds the byte at pc_r in the same instruction cycle
// Notes:   one clock edge is one instruction cycle; other opcodes just step
//
// Functional notes
// - prefixed 3e drives pointer digit to port
// - prefixed 5y writes immediate to general port
// - prefixed 3a copies ram nibble to general port
// - prefixed 3b copies ram to secondary port
// - serial swap exchanges accumulator and shift register
// - serial swap copies carry into clock latch
// - second processor treats serial swap as no-op
// - program memory pages are 64 words
// - counter advances before each instruction executes
// - short jump replaces only low six bits
// - jump from page last word lands next page
// - top bits 11 mark the short jump
// - inside pages two and three load seven bits
// - short call always lands in page two
// - top bits 10 mark call; bf is lookup
`timescale 1ns/1ps
`default_nettype none
module popjd_decoder
    import popjd_pkg::*;
#(
    parameter int          PC_W            = 10,
    parameter int          STACK_DEPTH     = 3,
    parameter logic [7:0]  SWAP_OPCODE     = 8'h4f,
    parameter logic        SECOND_CPU      = 1'b0,
    parameter logic        HAS_SECOND_PORT = 1'b1
)(
    input  wire logic            clk,
    input  wire logic            rstn,
    // program fetch
    input  wire logic [7:0]      rom_data,
    output logic      [PC_W-1:0] pc_r,
    // data path inputs
    input  wire logic [3:0]      ram_nibble,
    input  wire logic [3:0]      pointer_digit_field,
    input  wire logic            carry_in,
    // register port
    input  wire logic [1:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [7:0]      reg_rdata_r,
    // nibble ports and serial state
    output logic      [3:0]      digit_port_r,
    output logic      [3:0]      general_port_r,
    output logic      [3:0]      secondary_port_r,
    output logic      [3:0]      acc_r,
    output logic      [3:0]      serial_shift_register_r,
    output logic                 serial_clock_latch_r,
    // deferred work and stack
    output logic                 table_op_r,
    output logic      [PC_W-1:0] stack_top
);
    // =========================================================================
    // page geometry check
    // sanity: the page width used by the target logic matches the page size
    localparam logic PAGE_OK = ((1 << PAGE_BITS) == PAGE_WORDS);

    // =========================================================================
    // state and decode signals
    popjd_state_t    state_r;
    popjd_state_t    state_nxt;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] pc_nxt;
    logic            in_fetch;
    logic            is_prefix;
    logic            is_swap;
    logic            swap_en;
    logic            do_digit;
    logic            do_imm;
    logic            do_ram_g;
    logic            do_ram_h;
    logic            do_call;
    logic            is_table;
    logic            acc_wr_en;
    logic            shift_wr_en;

    popjd_pc_if #(.PC_W(PC_W)) pcj ();

    // =========================================================================
    // page target and stack
    popjd_page_target #(
        .PC_W (PC_W)
    ) u_target (
        .pc (pcj.target)
    );

    popjd_return_stack #(
        .PC_W  (PC_W),
        .DEPTH (STACK_DEPTH)
    ) u_stack (
        .clk       (clk),
        .rstn      (rstn),
        .push      (do_call),
        .push_data (pc_inc),
        .top       (stack_top)
    );

    // =========================================================================
    // counter advance
    // every byte advances the counter before it is acted on
    assign pc_inc     = pc_r + PC_W'(1);
    assign pcj.pc_inc = pc_inc;
    assign pcj.opcode = rom_data;

    // =========================================================================
    // instruction decode
    assign in_fetch  = (state_r == ST_FETCH);
    assign is_prefix = in_fetch && (rom_data == OP_PREFIX);
    assign is_swap   = in_fetch && (rom_data == SWAP_OPCODE);
    // the second processor sees the swap opcode but does nothing with it
    assign swap_en   = is_swap && !SECOND_CPU;
    assign is_table  = in_fetch
                       && (rom_data == OP_TABLE_JUMP || rom_data == OP_TABLE_LOOKUP);
    assign do_call   = in_fetch && !is_prefix && !is_swap
                       && (pcj.kind == JK_CALL);

    // second byte of a prefixed instruction
    assign do_digit  = !in_fetch && (rom_data == OP2_DIGIT_OUT);
    assign do_imm    = !in_fetch && (rom_data[7:4] == OP2_IMM_HI);
    assign do_ram_g  = !in_fetch && (rom_data == OP2_RAM_GENERAL);
    // the secondary port only answers where it is built
    assign do_ram_h  = !in_fetch && (rom_data == OP2_RAM_SECOND)
                       && HAS_SECOND_PORT;

    // register port writes
    assign acc_wr_en = reg_wr && (reg_addr == REG_ACC);
    assign shift_wr_en = reg_wr && (reg_addr == REG_SERIAL);

    // =========================================================================
    // sequencing
    always_comb begin
        state_nxt = ST_FETCH;
        pc_nxt    = pc_inc;
        unique case (state_r)
            ST_FETCH: begin
                if (is_prefix) begin
                    // two-byte forms take the second cycle to execute
                    state_nxt = ST_SECOND;
                end else if (!is_swap && pcj.kind != JK_STEP) begin
                    pc_nxt = pcj.pc_target;
                end
            end
            ST_SECOND: begin
                // any second byte ends the instruction; unknown ones act as no-ops
                state_nxt = ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= ST_FETCH;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pc_r <= '0;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    // =========================================================================
    // output ports
    always_ff @(posedge clk) begin
        if (!rstn) begin
            digit_port_r <= RST_NIBBLE;
        end else if (do_digit) begin
            digit_port_r <= pointer_digit_field;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            general_port_r <= RST_NIBBLE;
        end else if (do_imm) begin
            general_port_r <= rom_data[3:0];
        end else if (do_ram_g) begin
            general_port_r <= ram_nibble;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            secondary_port_r <= RST_NIBBLE;
        end else if (do_ram_h) begin
            secondary_port_r <= ram_nibble;
        end
    end

    // =========================================================================
    // accumulator and serial exchange
    // the swap beats a register write in the same cycle so software cannot
    // lose the value the serial side just delivered
    always_ff @(posedge clk) begin
        if (!rstn) begin
            acc_r <= RST_NIBBLE;
        end else if (swap_en) begin
            acc_r <= serial_shift_register_r;
        end else if (acc_wr_en) begin
            acc_r <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            serial_shift_register_r <= RST_NIBBLE;
        end else if (swap_en) begin
            serial_shift_register_r <= acc_r;
        end else if (shift_wr_en) begin
            serial_shift_register_r <= reg_wdata[3:0];
        end
    end

    // carry is only read here, never written, so it stays as it was
    always_ff @(posedge clk) begin
        if (!rstn) begin
            serial_clock_latch_r <= RST_BIT;
        end else if (swap_en) begin
            serial_clock_latch_r <= carry_in;
        end
    end

    // =========================================================================
    // deferred table opcodes
    // table jump and lookup are executed elsewhere; flag them for one cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            table_op_r <= RST_BIT;
        end else begin
            table_op_r <= is_table;
        end
    end

    // =========================================================================
    // register read port
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata_r <= RST_BYTE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_ACC:    reg_rdata_r <= {4'h0, acc_r};
                REG_SERIAL: reg_rdata_r <= {4'h0, serial_shift_register_r};
                REG_STATUS: reg_rdata_r <= {5'h00, PAGE_OK, serial_clock_latch_r,
                                            state_r};
                REG_PORTS:  reg_rdata_r <= {secondary_port_r, general_port_r};
            endcase
        end else begin
            // data stand for one cycle only after a read
            reg_rdata_r <= RST_BYTE;
        end
    end

endmodule
`default_nettype wire

//--- popjd_pkg.sv
// Purpose: shared constants and types of the port output and page jump decoder
// Assumes: one clock edge is one instruction cycle
// Notes:   opcodes, page geometry, register offsets and reset values live here
`default_nettype none
package popjd_pkg;
    // =========================================================================
    // opcodes
    localparam logic [7:0] OP_PREFIX        = 8'h33;
    localparam logic [7:0] OP2_DIGIT_OUT    = 8'h3e;
    localparam logic [7:0] OP2_RAM_GENERAL  = 8'h3a;
    localparam logic [7:0] OP2_RAM_SECOND   = 8'h3b;
    localparam logic [3:0] OP2_IMM_HI       = 4'h5;
    localparam logic [7:0] OP_TABLE_JUMP    = 8'hff;
    localparam logic [7:0] OP_TABLE_LOOKUP  = 8'hbf;
    localparam logic [1:0] OP_JUMP_TOP      = 2'b11;
    localparam logic [1:0] OP_CALL_TOP      = 2'b10;
    // =========================================================================
    // program memory geometry
    localparam int PAGE_BITS    = 6;
    localparam int PAGE_WORDS   = 64;
    localparam int SUB_BITS     = 7;
    localparam int SUB_PAGE_LO  = 2;
    localparam int SUB_PAGE_HI  = 3;
    // =========================================================================
    // register port offsets
    localparam logic [1:0] REG_ACC    = 2'h0;
    localparam logic [1:0] REG_SERIAL = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam logic [1:0] REG_PORTS  = 2'h3;
    // =========================================================================
    // reset values
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic       RST_BIT    = 1'b0;
    // =========================================================================
    // types
    typedef enum logic [0:0] {
        ST_FETCH  = 1'b0,
        ST_SECOND = 1'b1
    } popjd_state_t;
    typedef enum logic [1:0] {
        JK_STEP = 2'b00,
        JK_PAGE = 2'b01,
        JK_CALL = 2'b10
    } popjd_jkind_t;
endpackage
`default_nettype wire

//--- popjd_pc_if.sv
// Purpose: carries the incremented counter and opcode to the target logic
// Assumes: purely combinational between the two ends
// Notes:   kind tells the decoder which way the counter goes
`timescale 1ns/1ps
`default_nettype none
interface popjd_pc_if
    import popjd_pkg::*;
#(
    parameter int PC_W = 10
);
    logic [PC_W-1:0] pc_inc;
    logic [7:0]      opcode;
    logic [PC_W-1:0] pc_target;
    popjd_jkind_t    kind;
    modport decode (output pc_inc, output opcode, input pc_target, input kind);
    modport target (input pc_inc, input opcode, output pc_target, output kind);
endinterface
`default_nettype wire

//--- popjd_page_target.sv
// Purpose: forms jump targets from the incremented counter and call targets in page two
// Assumes: pc_inc already holds the counter advanced past the opcode
// Notes:   table opcodes pass through as a plain step
`timescale 1ns/1ps
`default_nettype none
module popjd_page_target
    import popjd_pkg::*;
#(
    parameter int PC_W = 10
)(
    popjd_pc_if.target pc
);
    localparam int PG_W = PC_W - PAGE_BITS;
    logic [PG_W-1:0] page;
    logic            in_sub;
    always_comb begin
        page   = pc.pc_inc[PC_W-1:PAGE_BITS];
        in_sub = (page == PG_W'(SUB_PAGE_LO)) || (page == PG_W'(SUB_PAGE_HI));
        pc.kind      = JK_STEP;
        pc.pc_target = pc.pc_inc;
        if (pc.opcode == OP_TABLE_JUMP || pc.opcode == OP_TABLE_LOOKUP) begin
            pc.kind = JK_STEP;
        end else if (in_sub && pc.opcode[7]) begin
            pc.kind      = JK_PAGE;
            pc.pc_target = {pc.pc_inc[PC_W-1:SUB_BITS], pc.opcode[SUB_BITS-1:0]};
        end else if (pc.opcode[7:6] == OP_JUMP_TOP) begin
            // upper bits come from the advanced counter, so a jump on a last word crosses
            pc.kind      = JK_PAGE;
            pc.pc_target = {pc.pc_inc[PC_W-1:PAGE_BITS], pc.opcode[PAGE_BITS-1:0]};
        end else if (pc.opcode[7:6] == OP_CALL_TOP) begin
            pc.kind      = JK_CALL;
            pc.pc_target = {PG_W'(SUB_PAGE_LO), pc.opcode[PAGE_BITS-1:0]};
        end
    end
endmodule
`default_nettype wire

//--- popjd_return_stack.sv
// Purpose: subroutine return stack, pushed by the short call
// Assumes: returns are handled outside this block
// Notes:   oldest entry falls off the bottom when the stack overflows
`timescale 1ns/1ps
`default_nettype none
module popjd_return_stack #(
    parameter int PC_W  = 10,
    parameter int DEPTH = 3
)(
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            push,
    input  wire logic [PC_W-1:0] push_data,
    output logic      [PC_W-1:0] top
);
    logic [PC_W-1:0] entry_r [DEPTH];
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_lvl
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    entry_r[i] <= '0;
                end else if (push) begin
                    entry_r[i] <= (i == 0) ? push_data : entry_r[(i == 0) ? 0 : i-1];
                end
            end
        end
    endgenerate
    assign top = entry_r[0];
endmodule
`default_nettype wire

//--- popjd_sva.sv
// Purpose: port-level checker for the port output and page jump decoder
// Assumes: one clock edge is one instruction cycle
// Notes:   prefix tracking mirrors the two-byte framing so checks see second bytes
`timescale 1ns/1ps
`default_nettype none
module popjd_sva
    import popjd_pkg::*;
#(
    parameter int         PC_W            = 10,
    parameter logic [7:0] SWAP_OPCODE     = 8'h4f,
    parameter logic       SECOND_CPU      = 1'b0,
    parameter logic       HAS_SECOND_PORT = 1'b1
)(
    input wire logic            clk,
    input wire logic            rstn,
    input wire logic [7:0]      rom_data,
    input wire logic [PC_W-1:0] pc_r,
    input wire logic [3:0]      ram_nibble,
    input wire logic [3:0]      pointer_digit_field,
    input wire logic            carry_in,
    input wire logic [3:0]      digit_port_r,
    input wire logic [3:0]      general_port_r,
    input wire logic [3:0]      secondary_port_r,
    input wire logic [3:0]      acc_r,
    input wire logic [3:0]      serial_shift_register_r,
    input wire logic            serial_clock_latch_r,
    input wire logic            table_op_r,
    input wire logic [PC_W-1:0] stack_top
);
    // =========================================================================
    // helper logic
    logic            pfx_r;
    logic            fst;
    logic            sub_pg;
    logic [PC_W-1:0] inc;
    assign inc = pc_r + 1'b1;
    assign fst = !pfx_r;
    assign sub_pg = inc[PC_W-1:7] == (PC_W-7)'(1);
    // a second 33 is only a second byte, so the flag never chains
    always_ff @(posedge clk) begin
        pfx_r <= rstn && !pfx_r && (rom_data == OP_PREFIX);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // =========================================================================
    // assertions
    a_digit_out:
        assert property (pfx_r && rom_data == OP2_DIGIT_OUT
            |=> digit_port_r == $past(pointer_digit_field)) else $error("digit port wrong");
    a_imm_out:
        assert property (pfx_r && rom_data[7:4] == OP2_IMM_HI
            |=> general_port_r == $past(rom_data[3:0])) else $error("immediate port wrong");
    a_ram_general:
        assert property (pfx_r && rom_data == OP2_RAM_GENERAL
            |=> general_port_r == $past(ram_nibble)) else $error("general port wrong");
    a_ram_second:
        assert property (HAS_SECOND_PORT && pfx_r && rom_data == OP2_RAM_SECOND
            |=> secondary_port_r == $past(ram_nibble)) else $error("secondary port wrong");
    a_swap_xchg:
        assert property (!SECOND_CPU && fst && rom_data == SWAP_OPCODE
            |=> acc_r == $past(serial_shift_register_r)
            && serial_shift_register_r == $past(acc_r)) else $error("swap wrong");
    a_swap_latch:
        assert property (!SECOND_CPU && fst && rom_data == SWAP_OPCODE
            |=> serial_clock_latch_r == $past(carry_in)) else $error("clock latch wrong");
    a_swap_noop:
        assert property (SECOND_CPU && fst && rom_data == SWAP_OPCODE
            |=> serial_clock_latch_r == $past(serial_clock_latch_r))
            else $error("swap not ignored");
    a_second_absent:
        assert property (!HAS_SECOND_PORT |-> secondary_port_r == RST_NIBBLE)
            else $error("absent secondary port driven");
    a_second_step:
        assert property (pfx_r |=> pc_r == $past(inc)) else $error("second byte not stepped");
    a_page_jump:
        assert property (fst && rom_data[7:6] == OP_JUMP_TOP && rom_data != OP_TABLE_JUMP
            && !sub_pg |=> pc_r == {$past(inc[PC_W-1:6]), $past(rom_data[5:0])})
            else $error("page jump wrong");
    a_sub_jump:
        assert property (fst && rom_data[7] && rom_data != OP_TABLE_JUMP
            && rom_data != OP_TABLE_LOOKUP && sub_pg
            |=> pc_r == {$past(inc[PC_W-1:7]), $past(rom_data[6:0])})
            else $error("subroutine page jump wrong");
    a_short_call:
        assert property (fst && rom_data[7:6] == OP_CALL_TOP && rom_data != OP_TABLE_LOOKUP
            && !sub_pg |=> pc_r == {{(PC_W-8){1'b0}}, 2'b10, $past(rom_data[5:0])}
            && stack_top == $past(inc)) else $error("short call wrong");
    a_table_step:
        assert property (fst && (rom_data == OP_TABLE_JUMP || rom_data == OP_TABLE_LOOKUP)
            |=> pc_r == $past(inc) && table_op_r) else $error("table opcode wrong");
    a_reset_clear:
        assert property (disable iff (1'b0) !rstn |=> pc_r == '0 && acc_r == RST_NIBBLE
            && general_port_r == RST_NIBBLE) else $error("reset state wrong");
endmodule
bind popjd_decoder popjd_sva #(.PC_W(PC_W), .SWAP_OPCODE(SWAP_OPCODE), .SECOND_CPU(SECOND_CPU),
    .HAS_SECOND_PORT(HAS_SECOND_PORT)) u_sva (
    .clk(clk), .rstn(rstn), .rom_data(rom_data), .pc_r(pc_r), .ram_nibble(ram_nibble),
    .pointer_digit_field(pointer_digit_field), .carry_in(carry_in),
    .digit_port_r(digit_port_r), .general_port_r(general_port_r),
    .secondary_port_r(secondary_port_r), .acc_r(acc_r),
    .serial_shift_register_r(serial_shift_register_r),
    .serial_clock_latch_r(serial_clock_latch_r), .table_op_r(table_op_r),
    .stack_top(stack_top)
);
`default_nettype wire

//--- popjd_rom_model.sv
// Purpose: program memory standing in front of the decoder
// Assumes: combinational read, loaded by the bench after time zero
// Notes:   empty words hold 00, which only steps the counter
`timescale 1ns/1ps
`default_nettype none
module popjd_rom_model
    import popjd_pkg::*;
#(
    parameter int PC_W = 10
)(
    input  wire logic [PC_W-1:0] addr,
    output logic      [7:0]      data
);
    logic [7:0] mem [(1<<PC_W)];
    initial begin
        for (int i = 0; i < (1 << PC_W); i++) begin
            mem[i] = RST_BYTE;
        end
    end
    assign data = mem[addr];
endmodule
`default_nettype wire

//--- popjd_decoder_bench.sv
// Purpose: self-checking bench for the port output and page jump decoder
// Assumes: pointer digit 9 and ram nibble 6; a second instance lacks swap and secondary port
// Notes:   one program trace is checked row by row, then registers and reset
`timescale 1ns/1ps
`default_nettype none
module popjd_decoder_bench
    import popjd_pkg::*;
;
    typedef struct packed {
        logic [9:0] pc;
        logic [3:0] gen;
        logic       tbl;
        logic       wr;
        logic [1:0] addr;
        logic [3:0] data;
    } popjd_row_t;
    logic            clk;
    logic            rstn;
    logic            carry_in;
    logic            reg_wr;
    logic            reg_rd;
    logic            table_op_r;
    logic            serial_clock_latch_r;
    logic [1:0]      reg_addr;
    logic [3:0]      ram_nibble, pointer_digit_field, digit_port_r, general_port_r;
    logic [3:0]      secondary_port_r, acc_r, serial_shift_register_r;
    logic [7:0]      rom_data, reg_wdata, reg_rdata_r;
    logic [9:0]      pc_r, stack_top;
    logic [3:0]      y_acc, y_second;
    logic            y_latch;
    logic [7:0]      prog [10];
    popjd_row_t      rows [19];
    int              error_cnt;
    int              checks_done;

    popjd_decoder #(.PC_W(10)) dut (
        .clk(clk), .rstn(rstn), .rom_data(rom_data), .pc_r(pc_r), .ram_nibble(ram_nibble),
        .pointer_digit_field(pointer_digit_field), .carry_in(carry_in), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .digit_port_r(digit_port_r), .general_port_r(general_port_r),
        .secondary_port_r(secondary_port_r), .acc_r(acc_r),
        .serial_shift_register_r(serial_shift_register_r),
        .serial_clock_latch_r(serial_clock_latch_r), .table_op_r(table_op_r),
        .stack_top(stack_top)
    );
    // second processor without the secondary port, fed the same byte stream
    popjd_decoder #(.PC_W(10), .SECOND_CPU(1'b1), .HAS_SECOND_PORT(1'b0)) dut_y (
        .clk(clk), .rstn(rstn), .rom_data(rom_data), .pc_r(), .ram_nibble(ram_nibble),
        .pointer_digit_field(pointer_digit_field), .carry_in(carry_in), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(),
        .digit_port_r(), .general_port_r(), .secondary_port_r(y_second), .acc_r(y_acc),
        .serial_shift_register_r(), .serial_clock_latch_r(y_latch), .table_op_r(),
        .stack_top()
    );
    popjd_rom_model #(.PC_W(10)) rom (.addr(pc_r), .data(rom_data));

    // =========================================================================
    // tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        check(16'(reg_rdata_r), 16'(exp));
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // =========================================================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #(8 * 2000);
        error_cnt++;
        stop_test;
    end

    // =========================================================================
    // main sequence
    initial begin
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        carry_in = 1'b1;
        ram_nibble = 4'h6;
        pointer_digit_field = 4'h9;
        error_cnt = 0;
        checks_done = 0;
        #1;
        prog = '{8'h33, 8'h3e, 8'h33, 8'h5a, 8'h33, 8'h3a, 8'h33, 8'h3b, 8'h4f, 8'hfe};
        for (int i = 0; i < 10; i++) begin
            rom.mem[i] = prog[i];
        end
        // no call aims at 0bf; the call byte 81 at 085 sits in page two and jumps without a push
        rom.mem[10'h03f] = 8'hc5;
        rom.mem[10'h045] = 8'h85;
        rom.mem[10'h085] = 8'h81;
        rom.mem[10'h081] = 8'hff;
        rom.mem[10'h082] = 8'hbf;
        rom.mem[10'h083] = 8'hf0;
        rom.mem[10'h0f0] = 8'hc2;
        rows = '{'{10'h001, 4'h0, 1'b0, 1'b1, 2'h0, 4'h3}, '{10'h002, 4'h0, 1'b0, 1'b1, 2'h1, 4'hc},
                 '{10'h003, 4'h0, 1'b0, 1'b0, 2'h0, 4'h0}, '{10'h004, 4'ha, 1'b0, 1'b0, 2'h0, 4'h0},
                 '{10'h005, 4'ha, 1'b0, 1'b0, 2'h0, 4'h0}, '{10'h006, 4'h6, 1'b0, 1'b0, 2'h0, 4'h0},
                 '{10'h007, 4'h6, 1'b0, 1'b0, 2'h0, 4'h0}, '{10'h008, 4'h6, 1'b0, 1'b0, 2'h0, 4'h0},
                 '{10'h009, 4'h6, 1'b0, 1'b0, 2'h0, 4'h0}, '{10'h03e, 4'h6, 1'b0, 1'b0, 2'h0, 4'h0},
                 '{10'h03f, 4'h6, 1'b0, 1'b0, 2'h0, 4'h0}, '{10'h045, 4'h6, 1'b0, 1'b0, 2'h0, 4'h0},
                 '{10'h085, 4'h6, 1'b0, 1'b0, 2'h0, 4'h0}, '{10'h081, 4'h6, 1'b0, 1'b0, 2'h0, 4'h0},
                 '{10'h082, 4'h6, 1'b1, 1'b0, 2'h0, 4'h0}, '{10'h083, 4'h6, 1'b1, 1'b0, 2'h0, 4'h0},
                 '{10'h0f0, 4'h6, 1'b0, 1'b0, 2'h0, 4'h0}, '{10'h0c2, 4'h6, 1'b0, 1'b0, 2'h0, 4'h0},
                 '{10'h0c3, 4'h6, 1'b0, 1'b0, 2'h0, 4'h0}};
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 19; i++) begin
            @(posedge clk);
            reg_wr    <= rows[i].wr;
            reg_addr  <= rows[i].addr;
            reg_wdata <= {4'h0, rows[i].data};
            #1;
            check(16'(pc_r), 16'(rows[i].pc));
            check(16'(general_port_r), 16'(rows[i].gen));
            check(16'(table_op_r), 16'(rows[i].tbl));
        end
        check(16'(digit_port_r), 16'h9);
        check(16'(secondary_port_r), 16'h6);
        check(16'(acc_r), 16'hc);
        check(16'(serial_shift_register_r), 16'h3);
        check(16'(serial_clock_latch_r), 16'h1);
        check(16'(stack_top), 16'h046);
        check(16'(y_acc), 16'h3);
        check(16'(y_latch), 16'h0);
        check(16'(y_second), 16'h0);
        $display("program trace test done");
        reg_read(2'h2, 8'h06);
        reg_read(2'h0, 8'h0c);
        // the port register is read-only, so this write must vanish
        reg_write(2'h3, 8'hff);
        reg_read(2'h3, 8'h66);
        $display("register test done");
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        #1;
        check(16'(pc_r), 16'h000);
        check(16'(digit_port_r), 16'h0);
        check(16'(serial_clock_latch_r), 16'h0);
        @(posedge clk);
        rstn <= 1'b1;
        // the first edge after release consumes the prefix at word zero
        @(posedge clk);
        #1;
        check(16'(pc_r), 16'h001);
        $display("mid-run reset test done");
        stop_test;
    end
endmodule
`default_nettype wire
